// file: logic/oag_top.sv
// Summary of operation
// - An 8-bit immediate comes straight from the instruction field, with no memory access.
// - Word and longword immediates are read from a literal table via PC-relative addressing.
// - Absolute access is a literal load into a register, then register-indirect access.
// - Long displacement is a literal load into index register zero, then indexed access.
// - Register-direct mode yields the register contents and forms no memory address.
// - Register-indirect address is the register contents; the register is not changed.
// - Post-increment uses the register as address, then adds 1, 2 or 4 to it.
// - Pre-decrement subtracts 1, 2 or 4 first, writes it back and uses it as address.
// - Short displacement is 4 bits, zero-extended, scaled by size, added to the register.
// - Indexed address is the register plus index register zero, neither modified.
// - Base displacement is 8 bits, zero-extended, scaled, added to the global base register.
// - PC-relative literals double the displacement for word, quadruple it for longword
//          and mask the low two PC bits for longword.
// - Byte and word loads are sign-extended to 32 bits.
// - Word addresses must be even and longword addresses a multiple of four, else error.
`default_nettype none
module oag_top
  import oag_pkg::*;
(
  // Clock and reset.
  input  wire logic                           clk,
  input  wire logic                           rst,
  // Request from decode.
  input  wire logic                           req_valid,
  input  wire oag_pkg::oag_mode_e             mode,
  input  wire logic [1:0]                     size,
  input  wire logic [oag_pkg::IMM_W-1:0]      imm_field,
  input  wire logic [oag_pkg::XLEN-1:0]       selected_general_register,
  input  wire logic [oag_pkg::XLEN-1:0]       index_register_zero,
  input  wire logic [oag_pkg::XLEN-1:0]       global_base_register,
  input  wire logic [oag_pkg::XLEN-1:0]       pc,
  // Load data returning from memory.
  input  wire logic                           load_valid,
  input  wire logic [oag_pkg::XLEN-1:0]       load_data,
  input  wire logic [1:0]                     load_size,
  // Result towards load/store unit and register file.
  output logic                                out_valid,
  output logic                                mem_access,
  output logic [oag_pkg::XLEN-1:0]            eff_addr,
  output logic                                operand_valid,
  output logic [oag_pkg::XLEN-1:0]            operand,
  output logic                                wb_valid,
  output logic [oag_pkg::XLEN-1:0]            wb_value,
  output logic                                addr_error,
  // Sign-extended load result.
  output logic                                load_out_valid,
  output logic [oag_pkg::XLEN-1:0]            load_out
);
  import oag_pkg::*;

  logic [XLEN-1:0] step;
  logic [XLEN-1:0] scaled4;
  logic [XLEN-1:0] scaled8;
  logic [XLEN-1:0] load_ext;
  logic [XLEN-1:0] next_addr;
  logic [XLEN-1:0] next_wb;
  logic            next_mem;
  logic            next_wb_valid;
  logic            next_op_valid;
  logic [XLEN-1:0] next_operand;
  logic            misaligned;

  // The 4-bit field goes through the same scaler, zero-padded to 8 bits.
  oag_scale u_scale4 (
    .disp   ({{(DISP8_W-DISP4_W){1'b0}}, imm_field[DISP4_W-1:0]}),
    .size   (size),
    .scaled (scaled4)
  );

  oag_scale u_scale8 (
    .disp   (imm_field),
    .size   (size),
    .scaled (scaled8)
  );

  oag_sext u_sext (
    .din  (load_data),
    .size (load_size),
    .dout (load_ext)
  );

  always_comb begin
    case (size)
      SZ_WORD: step = STEP_WORD;
      SZ_LONG: step = STEP_LONG;
      default: step = STEP_BYTE;
    endcase
  end

  // Long immediates, absolute addresses and long displacements are not modes of
  // their own: software composes them from a PC-relative literal load followed by an
  // indirect or indexed access, so only those two building blocks exist here.
  always_comb begin
    next_addr     = '0;
    next_wb       = selected_general_register;
    next_mem      = 1'b0;
    next_wb_valid = 1'b0;
    next_op_valid = 1'b0;
    next_operand  = '0;
    case (mode)
      OAG_M_IMM8: begin
        next_op_valid = 1'b1;
        next_operand  = {{(XLEN-IMM_W){1'b0}}, imm_field};
      end
      OAG_M_REG: begin
        next_op_valid = 1'b1;
        next_operand  = selected_general_register;
      end
      OAG_M_IND: begin
        next_mem  = 1'b1;
        next_addr = selected_general_register;
      end
      OAG_M_POSTINC: begin
        next_mem      = 1'b1;
        next_addr     = selected_general_register;
        next_wb_valid = 1'b1;
        next_wb       = selected_general_register + step;
      end
      OAG_M_PREDEC: begin
        next_mem      = 1'b1;
        next_wb_valid = 1'b1;
        next_wb       = selected_general_register - step;
        next_addr     = selected_general_register - step;
      end
      OAG_M_DISP4: begin
        next_mem  = 1'b1;
        next_addr = selected_general_register + scaled4;
      end
      OAG_M_IDX: begin
        next_mem  = 1'b1;
        next_addr = selected_general_register + index_register_zero;
      end
      OAG_M_GBRD: begin
        next_mem  = 1'b1;
        next_addr = global_base_register + scaled8;
      end
      OAG_M_PCREL: begin
        next_mem = 1'b1;
        if (size == SZ_LONG) begin
          next_addr = (pc & PC_LONG_MASK) + scaled8;
        end else begin
          next_addr = pc + scaled8;
        end
      end
      default: begin
        next_mem = 1'b0;
      end
    endcase
  end

  always_comb begin
    case (size)
      SZ_WORD: misaligned = next_addr[0];
      SZ_LONG: misaligned = |next_addr[1:0];
      default: misaligned = 1'b0;
    endcase
  end

  // Address path.
  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid     <= 1'b0;
      mem_access    <= 1'b0;
      eff_addr      <= '0;
      addr_error    <= 1'b0;
      operand_valid <= 1'b0;
      operand       <= '0;
    end else begin
      out_valid     <= req_valid;
      mem_access    <= req_valid & next_mem;
      eff_addr      <= next_addr;
      addr_error    <= req_valid & next_mem & misaligned;
      operand_valid <= req_valid & next_op_valid;
      operand       <= next_operand;
    end
  end

  // Write-back path; a faulting access leaves the register untouched.
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_valid <= 1'b0;
      wb_value <= '0;
    end else begin
      wb_valid <= req_valid & next_wb_valid & ~misaligned;
      wb_value <= next_wb;
    end
  end

  // Load return path.
  always_ff @(posedge clk) begin
    if (rst) begin
      load_out_valid <= 1'b0;
      load_out       <= '0;
    end else begin
      load_out_valid <= load_valid;
      load_out       <= load_ext;
    end
  end
endmodule
`default_nettype wire

// file: logic/oag_pkg.sv
`default_nettype none
package oag_pkg;
  localparam int unsigned XLEN       = 32;
  localparam int unsigned IMM_W      = 8;
  localparam int unsigned DISP4_W    = 4;
  localparam int unsigned DISP8_W    = 8;
  localparam int unsigned SEL_W      = 4;
  localparam int unsigned BYTE_MSB   = 7;
  localparam int unsigned WORD_MSB   = 15;
  localparam logic [1:0]  SZ_BYTE    = 2'h0;
  localparam logic [1:0]  SZ_WORD    = 2'h1;
  localparam logic [1:0]  SZ_LONG    = 2'h2;
  localparam logic [31:0] PC_LONG_MASK = 32'hfffffffc;
  localparam logic [31:0] STEP_BYTE  = 32'h1;
  localparam logic [31:0] STEP_WORD  = 32'h2;
  localparam logic [31:0] STEP_LONG  = 32'h4;
  localparam logic [1:0]  SH_BYTE    = 2'h0;
  localparam logic [1:0]  SH_WORD    = 2'h1;
  localparam logic [1:0]  SH_LONG    = 2'h2;

  // Addressing modes, one-hot.
  typedef enum logic [9:0] {
    OAG_M_IMM8    = 10'h001,
    OAG_M_REG     = 10'h002,
    OAG_M_IND     = 10'h004,
    OAG_M_POSTINC = 10'h008,
    OAG_M_PREDEC  = 10'h010,
    OAG_M_DISP4   = 10'h020,
    OAG_M_IDX     = 10'h040,
    OAG_M_GBRD    = 10'h080,
    OAG_M_PCREL   = 10'h100,
    OAG_M_NONE    = 10'h200
  } oag_mode_e;
endpackage
`default_nettype wire

// file: logic/oag_scale.sv
`default_nettype none
module oag_scale
  import oag_pkg::*;
(
  // Displacement and size.
  input  wire logic [oag_pkg::DISP8_W-1:0] disp,
  input  wire logic [1:0]                  size,
  // Scaled, zero-extended result.
  output logic      [oag_pkg::XLEN-1:0]    scaled
);
  logic [XLEN-1:0] zext;
  assign zext = {{(XLEN-DISP8_W){1'b0}}, disp};
  always_comb begin
    case (size)
      SZ_WORD: scaled = zext << SH_WORD;
      SZ_LONG: scaled = zext << SH_LONG;
      default: scaled = zext << SH_BYTE;
    endcase
  end
endmodule
`default_nettype wire

// file: logic/oag_sext.sv
`default_nettype none
module oag_sext
  import oag_pkg::*;
(
  // Raw load data and size.
  input  wire logic [oag_pkg::XLEN-1:0] din,
  input  wire logic [1:0]               size,
  // Register-width value.
  output logic      [oag_pkg::XLEN-1:0] dout
);
  always_comb begin
    case (size)
      SZ_BYTE: dout = {{(XLEN-BYTE_MSB-1){din[BYTE_MSB]}}, din[BYTE_MSB:0]};
      SZ_WORD: dout = {{(XLEN-WORD_MSB-1){din[WORD_MSB]}}, din[WORD_MSB:0]};
      default: dout = din;
    endcase
  end
endmodule
`default_nettype wire

// file: dv/oag_checker.sv
`default_nettype none
module oag_checker
  import oag_pkg::*;
(
  // Clock, reset and request.
  input wire logic                        clk,
  input wire logic                        rst,
  input wire logic                        req_valid,
  input wire oag_pkg::oag_mode_e          mode,
  input wire logic [1:0]                  size,
  input wire logic [oag_pkg::IMM_W-1:0]   imm_field,
  input wire logic [oag_pkg::XLEN-1:0]    selected_general_register,
  input wire logic [oag_pkg::XLEN-1:0]    index_register_zero,
  input wire logic [oag_pkg::XLEN-1:0]    global_base_register,
  // Results.
  input wire logic                        mem_access,
  input wire logic [oag_pkg::XLEN-1:0]    eff_addr,
  input wire logic [oag_pkg::XLEN-1:0]    operand,
  input wire logic                        wb_valid,
  input wire logic [oag_pkg::XLEN-1:0]    wb_value,
  input wire logic                        addr_error
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_imm_operand: assert property (req_valid && mode == OAG_M_IMM8 |=>
    !mem_access && operand == {24'h0, $past(imm_field)}) else $error("imm operand wrong");
  a_reg_direct: assert property (req_valid && mode == OAG_M_REG |=>
    !mem_access && operand == $past(selected_general_register)) else $error("reg operand wrong");
  a_ind_addr: assert property (req_valid && mode == OAG_M_IND |=>
    mem_access && !wb_valid && eff_addr == $past(selected_general_register))
    else $error("indirect address wrong");
  a_postinc_step: assert property (req_valid && mode == OAG_M_POSTINC && size == SZ_LONG
    && selected_general_register[1:0] == 2'h0 |=> wb_valid
    && wb_value == $past(selected_general_register) + 32'h4) else $error("post-increment wrong");
  a_predec_same: assert property (req_valid && mode == OAG_M_PREDEC && size == SZ_LONG |=>
    mem_access && eff_addr == $past(selected_general_register) - 32'h4 && eff_addr == wb_value)
    else $error("pre-decrement address wrong");
  a_idx_sum: assert property (req_valid && mode == OAG_M_IDX |=>
    eff_addr == $past(selected_general_register) + $past(index_register_zero))
    else $error("indexed address wrong");
  a_gbr_byte: assert property (req_valid && mode == OAG_M_GBRD && size == SZ_BYTE |=>
    eff_addr == $past(global_base_register) + $past(imm_field)) else $error("base disp wrong");
  a_word_align: assert property (req_valid && mode == OAG_M_IND && size == SZ_WORD
    && selected_general_register[0] |=> addr_error) else $error("odd word not flagged");
  cover property (req_valid && mode == OAG_M_POSTINC);
  cover property (req_valid && mode == OAG_M_PREDEC);
  cover property (req_valid && mode == OAG_M_PCREL);
endmodule
bind oag_top oag_checker chk_u (.clk, .rst, .req_valid, .mode, .size, .imm_field,
  .selected_general_register, .index_register_zero, .global_base_register, .mem_access,
  .eff_addr, .operand, .wb_valid, .wb_value, .addr_error);
`default_nettype wire

// file: dv/testbench.sv
`default_nettype none
module testbench
  import oag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, rv = 1'b0, lv = 1'b0;
  oag_mode_e   md = OAG_M_NONE;
  logic [1:0]  sz = 2'h0, lsz = 2'h0;
  logic [7:0]  imm = 8'h0;
  logic [31:0] rn = 32'h0, r0 = 32'h0, gb = 32'h0, pcv = 32'h0, ld = 32'h0;
  logic        ov, ma, opv, wv, ae, lov;
  logic [31:0] ea, op, wb, lo;
  int          num_errors = 0, checks_done = 0;
  always #2.5 clk = ~clk;
  oag_top dut_u (.clk, .rst, .req_valid(rv), .mode(md), .size(sz), .imm_field(imm),
    .selected_general_register(rn), .index_register_zero(r0), .global_base_register(gb),
    .pc(pcv), .load_valid(lv), .load_data(ld), .load_size(lsz), .out_valid(ov),
    .mem_access(ma), .eff_addr(ea), .operand_valid(opv), .operand(op), .wb_valid(wv),
    .wb_value(wb), .addr_error(ae), .load_out_valid(lov), .load_out(lo));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Called at a falling edge; the next falling edge sees the registered answer.
  // Requests therefore follow each other with no idle cycle between them.
  task automatic go(input oag_mode_e m, input logic [1:0] s, input logic [31:0] r);
    rv = 1'b1;
    md = m;
    sz = s;
    rn = r;
    @(negedge clk);
  endtask
  task automatic t_basic;
    imm = 8'ha5;
    go(OAG_M_IMM8, SZ_BYTE, 32'h0);
    chk(op, 32'ha5);
    chk(ma, 1'b0);
    chk(opv, 1'b1);
    chk(ov, 1'b1);
    go(OAG_M_REG, SZ_LONG, 32'h12345678);
    chk(op, 32'h12345678);
    chk(ea, 32'h0);
    chk(opv, 1'b1);
    go(OAG_M_IND, SZ_BYTE, 32'h2001);
    chk(ea, 32'h2001);
    chk(wv, 1'b0);
    chk(opv, 1'b0);
    chk(ma, 1'b1);
    r0 = 32'h20;
    go(OAG_M_IDX, SZ_WORD, 32'hfffffff0);
    chk(ea, 32'h10);
    chk(wv, 1'b0);
    $display("basic modes done");
  endtask
  task automatic t_step;
    for (int i = 0; i < 3; i++) begin
      go(OAG_M_POSTINC, 2'(i), 32'h100);
      chk(ea, 32'h100);
      chk(wb, 32'h100 + (32'h1 << i));
      chk(wv, 1'b1);
      go(OAG_M_PREDEC, 2'(i), 32'h100);
      chk(ea, 32'h100 - (32'h1 << i));
      chk(wb, 32'h100 - (32'h1 << i));
      chk(wv, 1'b1);
    end
    $display("step modes done");
  endtask
  task automatic t_disp;
    imm = 8'hf3;
    gb = 32'h4000;
    pcv = 32'h1006;
    for (int i = 0; i < 3; i++) begin
      go(OAG_M_DISP4, 2'(i), 32'h800);
      chk(ea, 32'h800 + (32'h3 << i));
      go(OAG_M_GBRD, 2'(i), 32'h0);
      chk(ea, 32'h4000 + (32'hf3 << i));
    end
    imm = 8'h03;
    go(OAG_M_PCREL, SZ_WORD, 32'h0);
    chk(ea, 32'h100c);
    chk(ma, 1'b1);
    go(OAG_M_PCREL, SZ_LONG, 32'h0);
    chk(ea, 32'h1010);
    $display("displacement modes done");
  endtask
  task automatic t_align;
    go(OAG_M_IND, SZ_WORD, 32'h101);
    chk(ae, 1'b1);
    go(OAG_M_POSTINC, SZ_LONG, 32'h102);
    chk(ae, 1'b1);
    chk(wv, 1'b0);
    go(OAG_M_IND, SZ_BYTE, 32'h103);
    chk(ae, 1'b0);
    go(OAG_M_IND, SZ_LONG, 32'h104);
    chk(ae, 1'b0);
    $display("alignment done");
  endtask
  task automatic t_load;
    rv = 1'b0;
    lv = 1'b1;
    ld = 32'h8081;
    for (int i = 0; i < 3; i++) begin
      lsz = 2'(i);
      @(negedge clk);
      chk(lo, i == 0 ? 32'hffffff81 : i == 1 ? 32'hffff8081 : 32'h8081);
      chk(lov, 1'b1);
    end
    lv = 1'b0;
    @(negedge clk);
    chk(lov, 1'b0);
    chk(ov, 1'b0);
    $display("load extension done");
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk(ov, 1'b0);
    t_basic;
    t_step;
    t_disp;
    t_align;
    t_load;
    summarize;
  end
  initial begin
    #20000;
    num_errors++;
    summarize;
  end
endmodule
`default_nettype wire
